// ### common/tbs_defs.vh
// Purpose: Constants shared by the tuning band selector.
// Assumes: Frequencies are whole hertz in a 30-bit field.
// Notes:   Sub-hertz breakpoints fall between integer codes, so a
//          break "just above x.9999 kHz" becomes a ">= next hertz" test.
`ifndef TBS_DEFS_VH
`define TBS_DEFS_VH

// ----------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------
`define TBS_ADDR_FREQ    8'h00
`define TBS_ADDR_CTRL    8'h04
`define TBS_ADDR_STATUS  8'h08
`define TBS_ADDR_ACCEPT  8'h0C
`define TBS_ADDR_REJECT  8'h10

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define TBS_CTRL_INCR    0
`define TBS_CTRL_UP      1
`define TBS_CTRL_WIDE    2
`define TBS_CTRL_MDC     3
`define TBS_CTRL_W       4
`define TBS_ST_BAND_HI   2
`define TBS_ST_SUB3B     3
`define TBS_ST_LF        4
`define TBS_ST_REJ       5

// ----------------------------------------------------------------------
// Band codes
// ----------------------------------------------------------------------
`define TBS_BAND_NONE    3'h0
`define TBS_BAND_1       3'h1
`define TBS_BAND_2       3'h2
`define TBS_BAND_3       3'h3
`define TBS_BAND_4       3'h4

// ----------------------------------------------------------------------
// Frequencies in hertz
// ----------------------------------------------------------------------
`define TBS_F_MIN        30'h0000_03E8
`define TBS_F_MAX        30'h3B9A_CA00
`define TBS_B12_NOM      30'h0003_D090
`define TBS_B12_DN       30'h0003_6EE8
`define TBS_B12_UP       30'h0004_0B28
`define TBS_B23_NOM      30'h00E4_E1C0
`define TBS_B23_DN       30'h00CD_FE60
`define TBS_B23_UP       30'h00FB_C520
`define TBS_SUB3A_SPAN   30'h004C_4B40
`define TBS_MDC_LO       30'h2FAF_0800
`define TBS_MDC_HI       30'h35A4_E900

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define TBS_FREQ_RST     30'h0000_0000
`define TBS_CTRL_RST     4'h0
`define TBS_DATA_RST     32'h0000_0000

`endif

// ### verilog/tbs_brk_sel.v
// Purpose: Picks the band 1/2 and band 2/3 breakpoints in force.
// Assumes: Pure combinational, fed from the same clock domain.
// Notes:   Wideband forces the nominal band 3 break in all directions.
`timescale 1ns/1ps
`default_nettype none
`include "tbs_defs.vh"

module tbs_brk_sel
(
  input  wire        i_incr,
  input  wire        i_up,
  input  wire        i_wide,
  output reg  [29:0] o_brk12,
  output reg  [29:0] o_brk23
);

  always @*
  begin
    o_brk12 = `TBS_B12_NOM;
    o_brk23 = `TBS_B23_NOM;
    if (i_incr && i_up)
    begin
      o_brk12 = `TBS_B12_UP;
      o_brk23 = `TBS_B23_UP;
    end
    else if (i_incr)
    begin
      o_brk12 = `TBS_B12_DN;
      o_brk23 = `TBS_B23_DN;
    end
    if (i_wide)
    begin
      o_brk23 = `TBS_B23_NOM;
    end
  end

endmodule
`default_nettype wire

// ### verilog/tbs_sat_cnt.v
// Purpose: Saturating event counter for request statistics.
// Assumes: One-cycle increment pulse on the block clock.
// Notes:   Holds at all ones so software never sees a wrap.
`timescale 1ns/1ps
`default_nettype none

module tbs_sat_cnt
#(
  parameter WIDTH = 16
)
(
  input  wire             i_clk,
  input  wire             i_rst,
  input  wire             i_inc,
  output reg  [WIDTH-1:0] o_count
);

  always @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      o_count <= {WIDTH{1'b0}};
    else if (i_inc && (o_count != {WIDTH{1'b1}}))
      o_count <= o_count + {{(WIDTH-1){1'b0}}, 1'b1};
  end

endmodule
`default_nettype wire

// ### verilog/tbs_top.v
// Purpose: Tuning band selector with a simple register port.
// Assumes: Processor writes FREQ, then CTRL; the CTRL write is the
//          request strobe carrying entry kind, direction and modes.
// Notes:   Rejected requests leave band and path outputs untouched.
//
// Local design decisions: strobed register access and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "tbs_defs.vh"

module tbs_top
#(
  parameter CNT_W = 16
)
(
  input  wire        I_REF_CLK,
  input  wire        I_RST,
  input  wire [7:0]  I_ADDR,
  input  wire [31:0] I_WDATA,
  input  wire        I_WR,
  input  wire        I_RD,
  output reg  [31:0] O_RDATA,
  output reg  [2:0]  O_BAND,
  output reg         O_SUB_3B,
  output reg         O_LF_SEL
);

  // --------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------
  reg  [29:0]         freq_reg;
  reg  [3:0]          ctrl_reg;
  reg                 rej_reg;
  reg  [31:0]         rdata_next;
  reg  [2:0]          band_next;
  reg                 in_range;
  reg                 sub3b_next;
  wire                wr_freq;
  wire                wr_ctrl;
  wire                req_incr;
  wire                req_up;
  wire                req_wide;
  wire                req_mdc;
  wire [29:0]         brk12;
  wire [29:0]         brk23;
  wire [29:0]         sub3_edge;
  wire                above_brk12;
  wire                above_brk23;
  wire                above_sub3;
  wire                in_full_range;
  wire                in_mdc_window;
  wire                wide_too_low;
  wire                band_lf;
  wire                accept;
  wire                reject;
  wire [CNT_W-1:0]    acc_count;
  wire [CNT_W-1:0]    rej_count;

  // --------------------------------------------------------------------
  // Address decode
  // --------------------------------------------------------------------
  assign wr_freq = I_WR && (I_ADDR == `TBS_ADDR_FREQ);
  assign wr_ctrl = I_WR && (I_ADDR == `TBS_ADDR_CTRL);

  assign req_incr = I_WDATA[`TBS_CTRL_INCR];
  assign req_up   = I_WDATA[`TBS_CTRL_UP];
  assign req_wide = I_WDATA[`TBS_CTRL_WIDE];
  assign req_mdc  = I_WDATA[`TBS_CTRL_MDC];

  // --------------------------------------------------------------------
  // Frequency and control registers
  // --------------------------------------------------------------------
  always @(posedge I_REF_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      freq_reg <= `TBS_FREQ_RST;
    end
    else if (wr_freq)
    begin
      freq_reg <= I_WDATA[29:0];
    end
  end

  always @(posedge I_REF_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      ctrl_reg <= `TBS_CTRL_RST;
    end
    else if (wr_ctrl)
    begin
      ctrl_reg <= I_WDATA[`TBS_CTRL_W-1:0];
    end
  end

  // --------------------------------------------------------------------
  // Breakpoint selection
  // --------------------------------------------------------------------
  tbs_brk_sel u_brk
  (
    .i_incr  (req_incr),
    .i_up    (req_up),
    .i_wide  (req_wide),
    .o_brk12 (brk12),
    .o_brk23 (brk23)
  );

  // 3A spans 5 MHz above break
  assign sub3_edge = brk23 + `TBS_SUB3A_SPAN;

  // --------------------------------------------------------------------
  // Breakpoint comparisons
  // --------------------------------------------------------------------
  // Each compare is a named wire; the range test below uses its own limit
  // compares and shares none of these break compares with the band choice.
  assign above_brk12 = (freq_reg >= brk12);
  assign above_brk23 = (freq_reg >= brk23);
  assign above_sub3  = (freq_reg >= sub3_edge);

  assign in_full_range = (freq_reg >= `TBS_F_MIN) &&
                         (freq_reg <= `TBS_F_MAX);

  assign in_mdc_window = (freq_reg >= `TBS_MDC_LO) &&
                         (freq_reg <= `TBS_MDC_HI);

  assign wide_too_low = req_wide && (freq_reg < `TBS_B23_NOM);

  // --------------------------------------------------------------------
  // Range check
  // --------------------------------------------------------------------
  // The downconverter window replaces the overall limits; wideband only
  // ever narrows them, so a low wideband request is refused outright.
  always @*
  begin
    in_range = in_full_range;
    if (req_mdc)
    begin
      in_range = in_mdc_window;
    end
    else if (wide_too_low)
    begin
      in_range = 1'b0;
    end
  end

  assign accept = wr_ctrl && in_range;
  assign reject = wr_ctrl && !in_range;

  // --------------------------------------------------------------------
  // Band decision
  // --------------------------------------------------------------------
  // The decision looks at the stored frequency and the flags on the bus
  // in the strobe cycle, so a mode change and a retune act as one step.
  always @*
  begin
    band_next  = `TBS_BAND_1;
    sub3b_next = 1'b0;
    if (req_mdc)
    begin
      band_next = `TBS_BAND_4;
    end
    else if (above_brk23)
    begin
      band_next  = `TBS_BAND_3;
      sub3b_next = above_sub3;
    end
    else if (above_brk12)
    begin
      band_next = `TBS_BAND_2;
    end
    else
    begin
      band_next = `TBS_BAND_1;
    end
  end

  assign band_lf = (band_next == `TBS_BAND_1) ||
                   (band_next == `TBS_BAND_2);

  // --------------------------------------------------------------------
  // Held band state
  // --------------------------------------------------------------------
  // Hysteresis comes from the directional breaks: a band moves only
  // when the frequency passes the break for the current travel.
  // hold band, skip rejects
  always @(posedge I_REF_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      O_BAND   <= `TBS_BAND_NONE;
      O_SUB_3B <= 1'b0;
    end
    else if (accept)
    begin
      O_BAND   <= band_next;
      O_SUB_3B <= sub3b_next;
    end
  end

  // one level for relay and switch
  always @(posedge I_REF_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      O_LF_SEL <= 1'b0;
    end
    else if (accept)
    begin
      O_LF_SEL <= band_lf;
    end
  end

  always @(posedge I_REF_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      rej_reg <= 1'b0;
    end
    else if (wr_ctrl)
    begin
      rej_reg <= !in_range;
    end
  end

  // --------------------------------------------------------------------
  // Request statistics
  // --------------------------------------------------------------------
  tbs_sat_cnt #(.WIDTH(CNT_W)) u_acc
  (
    .i_clk   (I_REF_CLK),
    .i_rst   (I_RST),
    .i_inc   (accept),
    .o_count (acc_count)
  );

  tbs_sat_cnt #(.WIDTH(CNT_W)) u_rej
  (
    .i_clk   (I_REF_CLK),
    .i_rst   (I_RST),
    .i_inc   (reject),
    .o_count (rej_count)
  );

  // --------------------------------------------------------------------
  // Read path
  // --------------------------------------------------------------------
  always @*
  begin
    rdata_next = `TBS_DATA_RST;
    case (I_ADDR)
      `TBS_ADDR_FREQ:
      begin
        rdata_next[29:0] = freq_reg;
      end
      `TBS_ADDR_CTRL:
      begin
        rdata_next[`TBS_CTRL_W-1:0] = ctrl_reg;
      end
      `TBS_ADDR_STATUS:
      begin
        rdata_next[`TBS_ST_BAND_HI:0] = O_BAND;
        rdata_next[`TBS_ST_SUB3B]     = O_SUB_3B;
        rdata_next[`TBS_ST_LF]        = O_LF_SEL;
        rdata_next[`TBS_ST_REJ]       = rej_reg;
      end
      `TBS_ADDR_ACCEPT:
      begin
        rdata_next[CNT_W-1:0] = acc_count;
      end
      `TBS_ADDR_REJECT:
      begin
        rdata_next[CNT_W-1:0] = rej_count;
      end
      default:
      begin
        rdata_next = `TBS_DATA_RST;
      end
    endcase
  end

  // Read data stand only in the cycle after the strobe; otherwise zero.
  always @(posedge I_REF_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      O_RDATA <= `TBS_DATA_RST;
    end
    else if (I_RD)
    begin
      O_RDATA <= rdata_next;
    end
    else
    begin
      O_RDATA <= `TBS_DATA_RST;
    end
  end

endmodule
`default_nettype wire

// ### verification/tbs_ctl_model.sv
// Purpose: Control processor model driving the register port.
// Assumes: Strobes are one cycle, driven just after a rising edge.
// Notes:   Released lines show inverted values so stale data is not trusted.
`timescale 1ns/1ps
`default_nettype none
module tbs_ctl_model
(
  input  wire logic        i_clk,
  input  wire logic [31:0] i_rdata,
  output var  logic [7:0]  o_addr,
  output var  logic [31:0] o_wdata,
  output var  logic        o_wr,
  output var  logic        o_rd
);
  initial
  begin
    o_addr = 8'h00;
    o_wdata = 32'h0000_0000;
    o_wr = 1'b0;
    o_rd = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    o_addr <= a;
    o_wdata <= d;
    o_wr <= 1'b1;
    @(posedge i_clk);
    o_wr <= 1'b0;
    o_addr <= ~a;
    o_wdata <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge i_clk);
    o_addr <= a;
    o_rd <= 1'b1;
    @(posedge i_clk);
    o_rd <= 1'b0;
    o_addr <= ~a;
    #1 d = i_rdata;
  endtask
endmodule
`default_nettype wire

// ### verification/tbs_top_properties.sv
// Purpose: Concurrent checks on the band selector ports.
// Assumes: FREQ is written before each CTRL request.
// Notes:   A FREQ shadow lets the checker predict nominal band 1/3, wideband, downconverter and range-reject outcomes.
`timescale 1ns/1ps
`default_nettype none
`include "tbs_defs.vh"
module tbs_top_properties
(
  input wire logic        I_REF_CLK,
  input wire logic        I_RST,
  input wire logic [7:0]  I_ADDR,
  input wire logic [31:0] I_WDATA,
  input wire logic        I_WR,
  input wire logic        I_RD,
  input wire logic [31:0] O_RDATA,
  input wire logic [2:0]  O_BAND,
  input wire logic        O_SUB_3B,
  input wire logic        O_LF_SEL
);
  logic [29:0] f_reg;
  wire         ctl = I_WR && I_ADDR == 8'h04;
  wire  [3:0]  m = I_WDATA[3:0];
  wire         ok = f_reg >= `TBS_F_MIN && f_reg <= `TBS_F_MAX;
  always @(posedge I_REF_CLK or posedge I_RST)
    if (I_RST)
      f_reg <= `TBS_FREQ_RST;
    else if (I_WR && I_ADDR == 8'h00)
      f_reg <= I_WDATA[29:0];
  default clocking cb @(posedge I_REF_CLK);
  endclocking
  default disable iff (I_RST);
  sequence s_rd;
    I_RD && I_ADDR == 8'h08;
  endsequence
  sequence s_req(c);
    ctl && c;
  endsequence
  property p_rd_idle;
    !I_RD |=> O_RDATA == 32'h0000_0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  property p_lf;
    O_LF_SEL == (O_BAND == `TBS_BAND_1 || O_BAND == `TBS_BAND_2);
  endproperty
  a_lf: assert property (p_lf) else $error("path select wrong");
  property p_sub;
    O_SUB_3B |-> O_BAND == `TBS_BAND_3;
  endproperty
  a_sub: assert property (p_sub) else $error("sub-band outside 3");
  property p_hold;
    !ctl |=> $stable({O_BAND, O_SUB_3B, O_LF_SEL});
  endproperty
  a_hold: assert property (p_hold) else $error("band moved");
  property p_status;
    s_rd |=> O_RDATA[4:0] == $past({O_LF_SEL, O_SUB_3B, O_BAND});
  endproperty
  a_status: assert property (p_status) else $error("status wrong");
  property p_b1;
    s_req(m == 4'h0 && ok && f_reg < `TBS_B12_NOM) |=> O_BAND == 3'h1;
  endproperty
  a_b1: assert property (p_b1) else $error("band 1 missed");
  property p_b3;
    s_req(m == 4'h0 && ok && f_reg >= `TBS_B23_NOM) |=> O_BAND == 3'h3
      && O_SUB_3B == (f_reg >= `TBS_B23_NOM + `TBS_SUB3A_SPAN);
  endproperty
  a_b3: assert property (p_b3) else $error("band 3 wrong");
  property p_mdc;
    s_req(m[3] && f_reg >= `TBS_MDC_LO && f_reg <= `TBS_MDC_HI)
      |=> O_BAND == `TBS_BAND_4 && !O_LF_SEL && !O_SUB_3B;
  endproperty
  a_mdc: assert property (p_mdc) else $error("band 4 wrong");
  property p_wide;
    s_req(m[3:2] == 2'h1 && f_reg < `TBS_B23_NOM) |=> $stable(O_BAND);
  endproperty
  a_wide: assert property (p_wide) else $error("wide low taken");
  property p_rej;
    s_req(!m[3] && !ok) |=> $stable({O_BAND, O_SUB_3B, O_LF_SEL});
  endproperty
  a_rej: assert property (p_rej) else $error("range reject");
endmodule
`default_nettype wire

// ### verification/test_tuning_band_selector.sv
// Purpose: Self-checking bench for the tuning band selector.
// Assumes: Register port driven by the processor model.
// Notes:   Rejected rows expect the band of the row before, or the reset band for the first.
`timescale 1ns/1ps
`default_nettype none
`include "tbs_defs.vh"
module test_tuning_band_selector;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata, d, st, n_acc = 0, n_rej = 0;
  logic        wr, rd, sub_3b, lf_sel;
  logic [2:0]  band;
  int          miscompares = 0;
  int          checks_done = 0;
  tbs_top uut (.I_REF_CLK(clk), .I_RST(rst), .I_ADDR(addr),
    .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata),
    .O_BAND(band), .O_SUB_3B(sub_3b), .O_LF_SEL(lf_sel));
  tbs_ctl_model ctl (.i_clk(clk), .i_rdata(rdata), .o_addr(addr),
    .o_wdata(wdata), .o_wr(wr), .o_rd(rd));
  initial forever #50 clk = ~clk;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic t(input logic [29:0] f, input logic [3:0] m,
    input logic [2:0] b, input logic s, input logic r);
    st = {26'h000_0000, r, b == 3'h1 || b == 3'h2, s, b};
    ctl.wr(8'h00, {2'b00, f});
    ctl.wr(8'h04, {28'h000_0000, m});
    ctl.rd(8'h08, d);
    chk(d, st);
    chk({27'h000_0000, lf_sel, sub_3b, band}, {27'h000_0000, st[4:0]});
    if (r)
      n_rej = n_rej + 1;
    else
      n_acc = n_acc + 1;
  endtask
  initial
  begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    ctl.rd(8'h08, d);
    chk({d[26:0], lf_sel, sub_3b, band}, 32'h0000_0000);
    $display("test reset done");
    t(`TBS_F_MIN-1, 4'h0, 3'h0, 0, 1);
    t(`TBS_F_MIN, 4'h0, 3'h1, 0, 0);
    t(`TBS_B12_NOM-1, 4'h0, 3'h1, 0, 0);
    t(`TBS_B12_NOM, 4'h0, 3'h2, 0, 0);
    t(`TBS_B23_NOM-1, 4'h0, 3'h2, 0, 0);
    t(`TBS_B23_NOM, 4'h0, 3'h3, 0, 0);
    t(`TBS_B23_NOM+`TBS_SUB3A_SPAN, 4'h0, 3'h3, 1, 0);
    t(`TBS_F_MAX+1, 4'h0, 3'h3, 1, 1);
    t(`TBS_B12_DN-1, 4'h1, 3'h1, 0, 0);
    t(`TBS_B12_DN, 4'h1, 3'h2, 0, 0);
    t(`TBS_B23_DN-1, 4'h1, 3'h2, 0, 0);
    t(`TBS_B23_DN, 4'h1, 3'h3, 0, 0);
    t(`TBS_B23_DN+`TBS_SUB3A_SPAN, 4'h1, 3'h3, 1, 0);
    t(`TBS_B12_UP-1, 4'h3, 3'h1, 0, 0);
    t(`TBS_B12_UP, 4'h3, 3'h2, 0, 0);
    t(`TBS_B23_UP-1, 4'h3, 3'h2, 0, 0);
    t(`TBS_B23_UP, 4'h3, 3'h3, 0, 0);
    t(`TBS_B23_UP+`TBS_SUB3A_SPAN, 4'h3, 3'h3, 1, 0);
    t(`TBS_B23_UP+`TBS_SUB3A_SPAN-1, 4'h3, 3'h3, 0, 0);
    t(`TBS_B12_NOM, 4'h2, 3'h2, 0, 0);
    t(`TBS_B23_NOM-1, 4'h4, 3'h2, 0, 1);
    t(`TBS_B23_NOM, 4'h7, 3'h3, 0, 0);
    t(`TBS_B23_NOM+`TBS_SUB3A_SPAN, 4'h7, 3'h3, 1, 0);
    t(`TBS_B23_NOM+`TBS_SUB3A_SPAN-1, 4'h5, 3'h3, 0, 0);
    t(`TBS_MDC_LO-1, 4'h8, 3'h3, 0, 1);
    t(`TBS_MDC_LO, 4'h8, 3'h4, 0, 0);
    t(`TBS_MDC_HI+1, 4'h8, 3'h4, 0, 1);
    t(`TBS_MDC_HI, 4'h8, 3'h4, 0, 0);
    $display("test bands done");
    ctl.rd(8'h0C, d);
    chk(d, n_acc);
    ctl.wr(8'h10, 32'h0000_0000);
    ctl.rd(8'h10, d);
    chk(d, n_rej);
    ctl.wr(8'h08, 32'hFFFF_FFFF);
    ctl.rd(8'h08, d);
    chk(d, st);
    ctl.rd(8'h20, d);
    chk(d, 32'h0000_0000);
    $display("test regs done");
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    #1 chk({29'h0000_0000, band}, 32'h0000_0000);
    ctl.rd(8'h0C, d);
    chk(d, 32'h0000_0000);
    ctl.rd(8'h08, d);
    chk(d, 32'h0000_0000);
    $display("test second reset done");
    conclude;
  end
  initial
  begin
    repeat (3000) @(posedge clk);
    miscompares++;
    conclude;
  end
endmodule
bind tbs_top tbs_top_properties u_props (.I_REF_CLK(I_REF_CLK),
  .I_RST(I_RST), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR),
  .I_RD(I_RD), .O_RDATA(O_RDATA), .O_BAND(O_BAND),
  .O_SUB_3B(O_SUB_3B), .O_LF_SEL(O_LF_SEL));
`default_nettype wire
